// [pkg/srx_if.sv]
// Serial link between the host port and the printer receiver.
`timescale 1ns/1ps
`default_nettype none
interface srx_if;
   logic rd;
   logic dsr;
   logic dtr;
   logic td;
   modport dev  (input rd, input dsr, output dtr, output td);
   modport host (output rd, output dsr, input dtr, input td);
endinterface : srx_if
`default_nettype wire

// [pkg/srx_pkg.sv]
// Types shared by both ends of the serial link.
package srx_pkg;
   typedef logic [7:0] srx_byte_t;
   typedef logic [2:0] srx_rate_t;
   typedef logic [3:0] srx_fmt_t;
   typedef enum logic [3:0] {
      SRX_RX_HUNT  = 4'b0001,
      SRX_RX_START = 4'b0010,
      SRX_RX_BITS  = 4'b0100,
      SRX_RX_STOP  = 4'b1000
   } srx_rx_state_t;
endpackage : srx_pkg

// [pkg/srx_regs.svh]
// Constants for the serial receiver with flow control: timing, thresholds and host registers.
`ifndef SRX_REGS_SVH
`define SRX_REGS_SVH

`define SRX_CLK_HZ          250000000
`define SRX_BASE_BAUD       150
`define SRX_HALF_BIT_150    (`SRX_CLK_HZ / (2 * `SRX_BASE_BAUD))

`define SRX_SMALL_CAP       13'h0048
`define SRX_LARGE_CAP       13'h1000
`define SRX_SMALL_OFF       13'h000A
`define SRX_SMALL_ON        13'h0014
`define SRX_LARGE_OFF       13'h0080
`define SRX_LARGE_ON        13'h0100

`define SRX_XON             8'h11
`define SRX_XOFF            8'h13
`define SRX_SUBST           8'h3F

`define SRX_FMT_SEVEN       0
`define SRX_FMT_PAR_EN      1
`define SRX_FMT_EVEN        2
`define SRX_FMT_XON         3

`define SRX_OFS_CTRL        8'h00
`define SRX_OFS_TXDATA      8'h04
`define SRX_OFS_STATUS      8'h08
`define SRX_OFS_RXDATA      8'h0C
`define SRX_CTRL_RATE_LSB   0
`define SRX_CTRL_FMT_LSB    3
`define SRX_CTRL_DSR_RDY    7
`define SRX_CTRL_RESET      32'h0000_0000

`endif

// [testbench/serial_receiver_flow_control_tb.sv]
// Bench joining the host port and the printer receiver over the link.
`timescale 1ns/1ps
`default_nettype none
module serial_receiver_flow_control_tb;
   import srx_pkg::*;
   localparam int unsigned HB = 512;
   logic clk, rst_i, hw, sel72, st, sreq, pop, bval, rxerr, busy, spend, rdy, hresp;
   logic pwr, onl;
   logic [2:0] srcsel;
   logic [1:0] ht;
   logic [31:0] ha, hwd, hrd, s;
   srx_fmt_t fmt;
   srx_rate_t rate;
   srx_byte_t sbyte, bdat, b;
   int seed, n_errors, checked, n_rxerr;
   srx_byte_t exp_q[$];
   srx_if lk ();
   srx_device #(.HALF_BIT_150(HB)) srx_device_inst (.clk_sys_i(clk), .rst_i(rst_i),
      .link(lk), .buffer_size_select_i(sel72), .serial_format_switches_i(fmt),
      .line_rate_switches_i(rate), .powerup_i(pwr), .selftest_i(st),
      .online_change_i(onl), .status_req_i(sreq), .status_byte_i(sbyte), .buf_pop_i(pop),
      .status_pend_o(spend), .buf_data_o(bdat), .buf_valid_o(bval), .rx_error_o(rxerr),
      .busy_o(busy));
   srx_host #(.HALF_BIT_150(HB)) srx_host_inst (.clk_sys_i(clk), .rst_i(rst_i), .link(lk),
      .hsel_i(1'b1), .haddr_i(ha), .htrans_i(ht), .hwrite_i(hw), .hsize_i(3'h2),
      .hwdata_i(hwd), .hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy), .hresp_o(hresp));
   srx_link_props #(.HALF_BIT_150(HB)) srx_link_props_inst (.clk_sys_i(clk), .rst_i(rst_i),
      .rd(lk.rd), .dsr(lk.dsr), .dtr(lk.dtr), .td(lk.td));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Counted on the falling edge so the registered pulse has settled.
   always @(negedge clk) if (rxerr === 1'b1) n_rxerr++;
   task automatic report_and_stop(input bit hung);
      if (hung) n_errors++;
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic hold();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         if (++n > 100) report_and_stop(1'b1);
      end while (rdy !== 1'b1);
   endtask : hold
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      ht <= 2'h2;
      hw <= w;
      ha <= {24'h00_0000, a};
      hold();
      ht <= 2'h0;
      hwd <= d;
      hold();
      q = hrd;
   endtask : ahb
   task automatic cfg(input srx_rate_t r, input srx_fmt_t hf, input srx_fmt_t df,
                      input logic dr);
      logic [31:0] q;
      rate <= r;
      fmt <= df;
      ahb(1'b1, 8'h00, {24'h00_0000, dr, hf, r}, q);
   endtask : cfg
   task automatic send(input srx_byte_t v, input logic ovr);
      logic [31:0] q;
      int n;
      ahb(1'b1, 8'h04, {24'h00_0000, v}, q);
      n = 0;
      // The busy source goes up only once the frame is on the wire.
      while (lk.rd !== 1'b0 && n < 9000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 9000) report_and_stop(1'b1);
      {pwr, onl, st} <= ovr ? srcsel : 3'h0;
      do begin
         ahb(1'b0, 8'h08, 32'h0000_0000, q);
         if (++n > 12000) report_and_stop(1'b1);
      end while (q[0] !== 1'b0);
      if (ovr) chk(busy, 1'b1);
      {pwr, onl, st} <= 3'h0;
   endtask : send
   task automatic poll(input int idx, input logic want);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         ahb(1'b0, 8'h08, 32'h0000_0000, q);
         n++;
      end while (q[idx] !== want && n < 400);
      chk(q[idx], want);
      chk(hresp, 1'b0);
   endtask : poll
   task automatic flow(input logic full);
      if (fmt[3]) poll(1, !full);
      else poll(3, full);
   endtask : flow
   task automatic pop_chk();
      pop <= 1'b1;
      @(posedge clk);
      pop <= 1'b0;
      #1;
      chk(bval, 1'b1);
      chk(bdat, exp_q.pop_front());
      @(posedge clk);
   endtask : pop_chk
   initial begin
      seed = 32'h9f15;
      {n_errors, checked, n_rxerr} = '0;
      rst_i = 1'b1;
      {hw, sel72, st, sreq, pop, ht, ha, hwd, fmt, rate, sbyte, pwr, onl, srcsel} = '0;
      repeat (4) @(posedge clk);
      #1;
      chk(busy, 1'b1);
      @(posedge clk);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 16; i++) begin
         cfg(3'(i < 8 ? i : 7), 4'(i % 8), 4'(i % 8), 1'b1);
         b = 8'($random(seed));
         send(b, 1'b0);
         exp_q.push_back(i % 2 ? b & 8'h7F : b);
         pop_chk();
      end
      chk(n_rxerr, 32'h0000_0000);
      // Parity mismatch, then a data bit of zero where a seven-bit stop is due.
      for (int i = 0; i < 2; i++) begin
         cfg(3'h7, i ? 4'h6 : 4'h2, i ? 4'h1 : 4'h6, 1'b1);
         send(i ? 8'h00 : 8'($random(seed)), 1'b0);
         exp_q.push_back(8'h3F);
         pop_chk();
      end
      cfg(3'h7, 4'h0, 4'h0, 1'b1);
      // Each busy source in turn makes the character on the wire an overrun.
      for (int j = 0; j < 3; j++) begin
         srcsel = 3'(1 << j);
         send(8'h5A, 1'b1);
         exp_q.push_back(8'h3F);
         pop_chk();
      end
      chk(n_rxerr, 32'h0000_0005);
      sel72 <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         cfg(3'h7, 4'(m * 8), 4'(m * 8), 1'b1);
         for (int k = 1; k <= 62; k++) begin
            b = 8'($random(seed)) | 8'h80;
            send(b, 1'b0);
            exp_q.push_back(b);
            if (k > 60) flow(k == 62);
         end
         repeat (10) pop_chk();
         repeat (200) @(posedge clk);
         flow(1'b1);
         pop_chk();
         flow(1'b0);
         while (exp_q.size() > 0) pop_chk();
      end
      for (int m = 0; m < 2; m++) begin
         cfg(3'h7, 4'(m * 8), 4'(m * 8), 1'b0);
         sbyte <= 8'($random(seed)) | 8'h80;
         sreq <= 1'b1;
         @(posedge clk);
         sreq <= 1'b0;
         repeat (300) @(posedge clk);
         chk(spend, m == 0);
         cfg(3'h7, 4'(m * 8), 4'(m * 8), 1'b1);
         poll(2, 1'b1);
         ahb(1'b0, 8'h0C, 32'h0000_0000, s);
         chk(s[7:0], sbyte);
      end
      report_and_stop(1'b0);
   end
endmodule : serial_receiver_flow_control_tb
`default_nettype wire

// [testbench/srx_link_props.sv]
// Timing and idle-level checks on the serial link between the two ends.
`timescale 1ns/1ps
`default_nettype none
module srx_link_props #(
   parameter int unsigned HALF_BIT_150 = 512
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic rd,
   input wire logic dsr,
   input wire logic dtr,
   input wire logic td
);
   // Space may last ten bits at the slowest rate; longer means a lost stop bit.
   localparam int unsigned MAXLOW = 20 * HALF_BIT_150 + 4;
   int unsigned rd_low_reg;
   int unsigned td_low_reg;
   default clocking cb @(posedge clk_sys_i); endclocking
   always_ff @(posedge clk_sys_i) rd_low_reg <= (rst_i || rd) ? '0 : rd_low_reg + 1;
   always_ff @(posedge clk_sys_i) td_low_reg <= (rst_i || td) ? '0 : td_low_reg + 1;
   a_dev_reset_idle: assert property (rst_i |=> td && dtr)
      else $error("device side not idle in reset");
   a_host_reset_idle: assert property (rst_i |=> rd && dsr)
      else $error("host side not idle in reset");
   a_release_idle: assert property ($fell(rst_i) |-> rd && td && dtr && dsr)
      else $error("link not idle at reset release");
   a_rd_bit_width: assert property (disable iff (rst_i) $changed(rd) |=> $stable(rd) [*7])
      else $error("rd bit too short");
   a_td_bit_width: assert property (disable iff (rst_i) $changed(td) |=> $stable(td) [*7])
      else $error("td bit too short");
   a_rd_low_bound: assert property (disable iff (rst_i) rd_low_reg <= MAXLOW)
      else $error("rd held at space too long");
   a_td_low_bound: assert property (disable iff (rst_i) td_low_reg <= MAXLOW)
      else $error("td held at space too long");
   a_dtr_no_chatter: assert property (disable iff (rst_i) $changed(dtr) |=> $stable(dtr) [*3])
      else $error("dtr chatters");
   c_td_frame: cover property (disable iff (rst_i) $fell(td));
   c_rd_frame: cover property (disable iff (rst_i) $fell(rd));
   c_dtr_mark: cover property (disable iff (rst_i) $rose(dtr));
endmodule : srx_link_props
`default_nettype wire

// [verilog/srx_device.sv]
// Printer end: serial receiver, input buffer, busy and XON/XOFF flow control.
`timescale 1ns/1ps
`default_nettype none
`include "srx_regs.svh"
module srx_device #(
   parameter int unsigned HALF_BIT_150 = `SRX_HALF_BIT_150,
   parameter int unsigned DEPTH        = 4096,
   parameter int unsigned AW           = 12
) (
   input  wire logic               clk_sys_i,
   input  wire logic               rst_i,
   srx_if.dev                      link,
   input  wire logic               buffer_size_select_i,
   input  wire srx_pkg::srx_fmt_t  serial_format_switches_i,
   input  wire srx_pkg::srx_rate_t line_rate_switches_i,
   input  wire logic               powerup_i,
   input  wire logic               selftest_i,
   input  wire logic               online_change_i,
   input  wire logic               status_req_i,
   input  wire srx_pkg::srx_byte_t status_byte_i,
   input  wire logic               buf_pop_i,
   output logic                    status_pend_o,
   output srx_pkg::srx_byte_t      buf_data_o,
   output logic                    buf_valid_o,
   output logic                    rx_error_o,
   output logic                    busy_o
);
   import srx_pkg::*;

   srx_rx_state_t state_reg;
   logic [19:0]   half_w;
   logic [20:0]   cnt_reg;
   logic [3:0]    idx_reg;
   logic [8:0]    bits_reg;
   logic          rd_prev_reg;
   logic          seven_w;
   logic          par_en_w;
   logic          xon_mode_w;
   logic [3:0]    last_w;
   logic          rx_done_w;
   srx_byte_t     rx_byte_w;
   logic          par_bit_w;
   logic          par_err_w;
   logic          frm_err_w;
   logic          bad_w;

   srx_byte_t     mem_reg [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0]   count_reg;
   logic [AW:0]   cap_w;
   logic [AW:0]   free_w;
   logic [AW:0]   off_th_w;
   logic [AW:0]   on_th_w;
   logic          push_w;
   logic          pop_w;

   logic          ext_busy_w;
   logic          lvl_busy_reg;
   logic          xoff_state_reg;
   logic          dtr_reg;
   logic          need_xoff_w;
   logic          need_xon_w;
   logic          status_go_w;
   logic          tx_start_w;
   srx_byte_t     tx_byte_w;
   logic          tx_busy_w;
   logic          txd_w;

   // The format and rate switches steer both the receiver and the transmitter; the XON bit also picks the flow control.
   assign seven_w    = serial_format_switches_i[`SRX_FMT_SEVEN];
   assign par_en_w   = serial_format_switches_i[`SRX_FMT_PAR_EN];
   assign xon_mode_w = serial_format_switches_i[`SRX_FMT_XON];
   // Rates double from 150 bit/s, so each step halves the divider.
   assign half_w     = 20'(HALF_BIT_150) >> line_rate_switches_i;
   assign last_w     = (seven_w ? 4'd6 : 4'd7) + {3'd0, par_en_w};

   // Receive sequencer: hunt, confirm start at half bit, then full-bit steps.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_reg   <= SRX_RX_HUNT;
         cnt_reg     <= 21'd0;
         idx_reg     <= 4'd0;
         bits_reg    <= 9'd0;
         rd_prev_reg <= 1'b1;
      end else begin
         rd_prev_reg <= link.rd;
         unique case (state_reg)
            SRX_RX_HUNT: begin
               if (rd_prev_reg && !link.rd) begin
                  state_reg <= SRX_RX_START;
                  cnt_reg   <= {1'b0, half_w} - 21'd1;
               end
            end
            SRX_RX_START: begin
               if (cnt_reg != 21'd0) begin
                  cnt_reg <= cnt_reg - 21'd1;
               end else if (link.rd) begin
                  state_reg <= SRX_RX_HUNT;
               end else begin
                  state_reg <= SRX_RX_BITS;
                  idx_reg   <= 4'd0;
                  bits_reg  <= 9'd0;
                  cnt_reg   <= {half_w, 1'b0} - 21'd1;
               end
            end
            SRX_RX_BITS: begin
               if (cnt_reg != 21'd0) begin
                  cnt_reg <= cnt_reg - 21'd1;
               end else begin
                  bits_reg[idx_reg] <= link.rd;
                  idx_reg           <= idx_reg + 4'd1;
                  cnt_reg           <= {half_w, 1'b0} - 21'd1;
                  if (idx_reg == last_w) begin
                     state_reg <= SRX_RX_STOP;
                  end
               end
            end
            SRX_RX_STOP: begin
               if (cnt_reg != 21'd0) begin
                  cnt_reg <= cnt_reg - 21'd1;
               end else begin
                  // Back to hunting at mid stop bit leaves half a bit for the next edge.
                  state_reg <= SRX_RX_HUNT;
               end
            end
         endcase
      end
   end

   assign rx_done_w = (state_reg == SRX_RX_STOP) && (cnt_reg == 21'd0);
   assign rx_byte_w = seven_w ? {1'b0, bits_reg[6:0]} : bits_reg[7:0];
   assign par_bit_w = seven_w ? bits_reg[7] : bits_reg[8];
   assign par_err_w = par_en_w &&
                      ((^rx_byte_w ^ par_bit_w) == serial_format_switches_i[`SRX_FMT_EVEN]);
   assign frm_err_w = !link.rd;
   assign bad_w     = par_err_w || frm_err_w || busy_o;

   // Buffer capacity and free space; storage is always the large depth.
   assign cap_w    = buffer_size_select_i ? `SRX_SMALL_CAP : `SRX_LARGE_CAP;
   assign free_w   = cap_w - count_reg;
   assign off_th_w = buffer_size_select_i ? `SRX_SMALL_OFF : `SRX_LARGE_OFF;
   assign on_th_w  = buffer_size_select_i ? `SRX_SMALL_ON : `SRX_LARGE_ON;
   // Intake is independent of the drain, so printing does not stop reception.
   assign push_w   = rx_done_w && (count_reg < cap_w);
   assign pop_w    = buf_pop_i && (count_reg != '0);

   always_ff @(posedge clk_sys_i) begin
      if (push_w) begin
         mem_reg[wptr_reg] <= bad_w ? `SRX_SUBST : rx_byte_w;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wptr_reg    <= '0;
         rptr_reg    <= '0;
         count_reg   <= '0;
         buf_data_o  <= 8'h00;
         buf_valid_o <= 1'b0;
         rx_error_o  <= 1'b0;
      end else begin
         buf_valid_o <= pop_w;
         rx_error_o  <= rx_done_w && bad_w;
         if (push_w) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop_w) begin
            buf_data_o <= mem_reg[rptr_reg];
            rptr_reg   <= rptr_reg + 1'b1;
         end
         count_reg <= count_reg + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};
      end
   end

   // Busy sources, with a fill-level hysteresis between the two thresholds.
   assign ext_busy_w = powerup_i || selftest_i || online_change_i;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         lvl_busy_reg <= 1'b1;
         busy_o       <= 1'b1;
         dtr_reg      <= 1'b1;
      end else begin
         if (free_w <= off_th_w) begin
            lvl_busy_reg <= 1'b1;
         end else if (free_w > on_th_w) begin
            lvl_busy_reg <= 1'b0;
         end
         busy_o  <= ext_busy_w || (xon_mode_w ? xoff_state_reg : lvl_busy_reg);
         // In software mode DTR stays at space and the byte stream carries flow.
         dtr_reg <= !xon_mode_w && (ext_busy_w || lvl_busy_reg);
      end
   end

   assign need_xoff_w = xon_mode_w && !xoff_state_reg &&
                        (ext_busy_w || free_w <= off_th_w);
   assign need_xon_w  = xon_mode_w && xoff_state_reg && !ext_busy_w &&
                        (free_w > on_th_w);
   assign status_go_w = status_pend_o && (xon_mode_w || !link.dsr);

   // Flow characters take the transmitter before status bytes.
   always_comb begin
      tx_start_w = 1'b0;
      tx_byte_w  = status_byte_i;
      if (!tx_busy_w) begin
         if (need_xoff_w) begin
            tx_start_w = 1'b1;
            tx_byte_w  = `SRX_XOFF;
         end else if (need_xon_w) begin
            tx_start_w = 1'b1;
            tx_byte_w  = `SRX_XON;
         end else if (status_go_w) begin
            tx_start_w = 1'b1;
         end
      end
   end

   // The off state starts set so that an XON announces readiness after reset.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         xoff_state_reg <= 1'b1;
      end else if (tx_start_w && (need_xoff_w || need_xon_w)) begin
         xoff_state_reg <= need_xoff_w;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         status_pend_o <= 1'b0;
      end else if (status_req_i) begin
         status_pend_o <= 1'b1;
      end else if (tx_start_w && !need_xoff_w && !need_xon_w) begin
         status_pend_o <= 1'b0;
      end
   end

   srx_tx #(
      .HALF_BIT_150 (HALF_BIT_150)
   ) u_tx (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .rate_i    (line_rate_switches_i),
      .fmt_i     (serial_format_switches_i),
      .start_i   (tx_start_w),
      .data_i    (tx_byte_w),
      .busy_o    (tx_busy_w),
      .txd_o     (txd_w)
   );

   assign link.dtr = dtr_reg;
   assign link.td  = txd_w;
endmodule : srx_device
`default_nettype wire

// [verilog/srx_host.sv]
// Host end: AHB-Lite controlled serial port that honours DTR or XON/XOFF.
`timescale 1ns/1ps
`default_nettype none
`include "srx_regs.svh"
module srx_host #(
   parameter int unsigned HALF_BIT_150 = `SRX_HALF_BIT_150
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   srx_if.host              link,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o
);
   import srx_pkg::*;
   logic [7:0]    ctrl_reg;
   logic          wr_ph_reg;
   logic [7:0]    wr_ofs_reg;
   logic          tx_pend_reg;
   srx_byte_t     tx_byte_reg;
   logic          xon_seen_reg;
   logic          rx_valid_reg;
   srx_byte_t     rx_byte_reg;
   logic          may_send_w;
   logic          tx_busy_w;
   logic          txd_w;
   logic          rd_hit_w;
   srx_rate_t     rate_w;
   srx_fmt_t      fmt_w;
   srx_rx_state_t st_reg;
   logic [20:0]   cnt_reg;
   logic [3:0]    idx_reg;
   logic [8:0]    bits_reg;
   logic          td_prev_reg;
   srx_byte_t     got_w;

   assign rate_w = ctrl_reg[`SRX_CTRL_RATE_LSB +: 3];
   assign fmt_w  = ctrl_reg[`SRX_CTRL_FMT_LSB +: 4];
   assign rd_hit_w = hsel_i && htrans_i[1] && !hwrite_i && hready_i;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         hreadyout_o <= 1'b0;
         hresp_o     <= 1'b0;
         hrdata_o    <= 32'h0000_0000;
         wr_ph_reg   <= 1'b0;
         wr_ofs_reg  <= 8'h00;
      end else begin
         hreadyout_o <= 1'b1;
         wr_ph_reg   <= hsel_i && htrans_i[1] && hwrite_i && hready_i;
         wr_ofs_reg  <= haddr_i[7:0];
         if (rd_hit_w) begin
            unique case (haddr_i[7:0])
               `SRX_OFS_CTRL:   hrdata_o <= {24'h00_0000, ctrl_reg};
               `SRX_OFS_STATUS: hrdata_o <= {28'h000_0000, link.dtr, rx_valid_reg,
                                             may_send_w, tx_pend_reg || tx_busy_w};
               `SRX_OFS_RXDATA: hrdata_o <= {24'h00_0000, rx_byte_reg};
               default:         hrdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl_reg <= 8'(`SRX_CTRL_RESET);
      end else if (wr_ph_reg && wr_ofs_reg == `SRX_OFS_CTRL) begin
         ctrl_reg <= hwdata_i[7:0];
      end
   end

   // Host sends only on DTR space, or after XON in software mode.
   assign may_send_w = fmt_w[`SRX_FMT_XON] ? xon_seen_reg : !link.dtr;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_pend_reg <= 1'b0;
         tx_byte_reg <= 8'h00;
      end else if (wr_ph_reg && wr_ofs_reg == `SRX_OFS_TXDATA && !tx_pend_reg) begin
         tx_pend_reg <= 1'b1;
         tx_byte_reg <= hwdata_i[7:0];
      end else if (tx_pend_reg && may_send_w && !tx_busy_w) begin
         tx_pend_reg <= 1'b0;
      end
   end

   srx_tx #(
      .HALF_BIT_150 (HALF_BIT_150)
   ) u_tx (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .rate_i    (rate_w),
      .fmt_i     (fmt_w),
      .start_i   (tx_pend_reg && may_send_w),
      .data_i    (tx_byte_reg),
      .busy_o    (tx_busy_w),
      .txd_o     (txd_w)
   );

   // Minimal receiver for flow characters and status bytes; no error checks.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_reg      <= SRX_RX_HUNT;
         cnt_reg     <= 21'd0;
         idx_reg     <= 4'd0;
         bits_reg    <= 9'd0;
         td_prev_reg <= 1'b1;
      end else begin
         td_prev_reg <= link.td;
         if (st_reg == SRX_RX_HUNT) begin
            if (td_prev_reg && !link.td) begin
               st_reg  <= SRX_RX_BITS;
               idx_reg <= 4'hF;
               cnt_reg <= 21'(HALF_BIT_150) >> rate_w;
            end
         end else if (cnt_reg != 21'd0) begin
            cnt_reg <= cnt_reg - 21'd1;
         end else if (st_reg == SRX_RX_BITS) begin
            if (idx_reg != 4'hF) begin
               bits_reg[idx_reg] <= link.td;
            end
            idx_reg <= idx_reg + 4'd1;
            cnt_reg <= (21'(HALF_BIT_150 * 2) >> rate_w) - 21'd1;
            if (idx_reg == (fmt_w[`SRX_FMT_SEVEN] ? 4'd6 : 4'd7) +
                           {3'd0, fmt_w[`SRX_FMT_PAR_EN]}) begin
               st_reg <= SRX_RX_STOP;
            end
         end else begin
            st_reg <= SRX_RX_HUNT;
         end
      end
   end

   assign got_w = fmt_w[`SRX_FMT_SEVEN] ? {1'b0, bits_reg[6:0]} : bits_reg[7:0];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         xon_seen_reg <= 1'b0;
         rx_valid_reg <= 1'b0;
         rx_byte_reg  <= 8'h00;
      end else if (st_reg == SRX_RX_STOP && cnt_reg == 21'd0) begin
         if (got_w == `SRX_XON) begin
            xon_seen_reg <= 1'b1;
         end else if (got_w == `SRX_XOFF) begin
            xon_seen_reg <= 1'b0;
         end else begin
            rx_valid_reg <= 1'b1;
            rx_byte_reg  <= got_w;
         end
      end else if (rd_hit_w && haddr_i[7:0] == `SRX_OFS_RXDATA) begin
         rx_valid_reg <= 1'b0;
      end
   end

   // The line idles at mark because the transmitter holds ones between frames.
   assign link.rd  = txd_w;
   assign link.dsr = !ctrl_reg[`SRX_CTRL_DSR_RDY];
endmodule : srx_host
`default_nettype wire

// [verilog/srx_tx.sv]
// Asynchronous serial transmitter with rate divider and configurable frame.
`timescale 1ns/1ps
`default_nettype none
`include "srx_regs.svh"
module srx_tx #(
   parameter int unsigned HALF_BIT_150 = `SRX_HALF_BIT_150
) (
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   input  wire srx_pkg::srx_rate_t rate_i,
   input  wire srx_pkg::srx_fmt_t  fmt_i,
   input  wire logic              start_i,
   input  wire srx_pkg::srx_byte_t data_i,
   output logic                   busy_o,
   output logic                   txd_o
);
   import srx_pkg::*;
   logic [20:0] full_w;
   logic [10:0] shift_reg;
   logic [3:0]  left_reg;
   logic [20:0] cnt_reg;
   logic        par_w;
   logic [10:0] frame_w;
   logic [3:0]  len_w;

   assign full_w = 21'(HALF_BIT_150 * 2) >> rate_i;
   always_comb begin
      par_w = fmt_i[`SRX_FMT_SEVEN] ? ^data_i[6:0] : ^data_i;
      par_w = fmt_i[`SRX_FMT_PAR_EN] ? (par_w ^ ~fmt_i[`SRX_FMT_EVEN]) : 1'b1;
      // Data go least significant bit first, parity after the last data bit.
      if (fmt_i[`SRX_FMT_SEVEN]) begin
         frame_w = {2'b11, par_w, data_i[6:0], 1'b0};
      end else begin
         frame_w = {1'b1, par_w, data_i, 1'b0};
      end
      len_w = 4'd10 - {3'd0, fmt_i[`SRX_FMT_SEVEN]} + {3'd0, fmt_i[`SRX_FMT_PAR_EN]};
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         shift_reg <= 11'h7FF;
         left_reg  <= 4'd0;
         cnt_reg   <= 21'd0;
         busy_o    <= 1'b0;
         txd_o     <= 1'b1;
      end else if (!busy_o) begin
         if (start_i) begin
            shift_reg <= frame_w;
            left_reg  <= len_w;
            cnt_reg   <= 21'd0;
            busy_o    <= 1'b1;
         end
      end else if (cnt_reg == 21'd0) begin
         txd_o     <= shift_reg[0];
         shift_reg <= {1'b1, shift_reg[10:1]};
         cnt_reg   <= full_w - 21'd1;
         if (left_reg == 4'd0) begin
            busy_o <= 1'b0;
         end else begin
            left_reg <= left_reg - 4'd1;
         end
      end else begin
         cnt_reg <= cnt_reg - 21'd1;
      end
   end
endmodule : srx_tx
`default_nettype wire
